// ===== design/dfrm_pkg.sv
// Function
// - a reset request from input, command bit or key clears the newest fault when that fault is resettable
// - after a fault reset the motor restarts only under power-up qualification
// - undervoltage and phase loss clear by themselves once the line is back
// - the forced-operation override inhibits every fault, thermal ones included
// - faults are monitored only while the override input reads one
// - any change of the override input clears all latched faults
// - restart waits are 1 s, 5 s, 10 s, then 60 s each
// - a restart attempt needs the fault gone and all run conditions met
// - total restart time is bounded: 5, 10, 30 min, 1, 2, 3 h or unlimited
// - when that time expires the unit locks until power is cycled
// - low line voltage always restarts automatically, even when not enabled
// - network faults clear when a command word or reference arrives again
// - the fault relay stays active while a restartable fault awaits restart with automatic restart enabled
// - probe faults recorded always, with power on, or while running
// - switch test runs before each start when enabled; the power-on request passes while the enable is still reset
// - external fault trips and flags when the input equals the set level
// - the contactor closes on run and opens once the motor is off
// - missing contactor feedback within the set time trips a fault
// - forced local mode accepts commands only from terminals or keypad; the code still takes a reset by the command bit (OFF_ACT write)
// - stops beat run; safe power removal beats everything
// - of two conflicting stop modes the first one activated is kept
// - a resettable fault applies the configured stop response
package dfrm_pkg;
    localparam int         CLK_HZ  = 20_000_000;
    localparam int         TICK_S  = 1;                  // tick period, seconds
    localparam int         TICK_CYC = TICK_S * CLK_HZ;
    localparam logic [13:0] WAIT1_S = 14'h0001;          // 1 s
    localparam logic [13:0] WAIT2_S = 14'h0005;          // 5 s
    localparam logic [13:0] WAIT3_S = 14'h000A;          // 10 s
    localparam logic [13:0] WAIT4_S = 14'h003C;          // 60 s
    localparam logic [13:0] DUR_5M  = 14'h012C;
    localparam logic [13:0] DUR_10M = 14'h0258;
    localparam logic [13:0] DUR_30M = 14'h0708;
    localparam logic [13:0] DUR_1H  = 14'h0E10;
    localparam logic [13:0] DUR_2H  = 14'h1C20;
    localparam logic [13:0] DUR_3H  = 14'h2A30;
    localparam int NF = 8;
    localparam int F_EXT = 0, F_PROBE = 1, F_UNDERV = 2, F_PHASE = 3;
    localparam int F_COMM = 4, F_OVV = 5, F_CONT = 6, F_SWT = 7;
    localparam logic [NF-1:0] RESTART_MASK = 8'h3F;
    localparam logic [NF-1:0] RESET_MASK   = 8'hF3;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CTMO = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] OFF_ACT  = 8'h0C;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [13:0] CTMO_RST = 14'h0005;
    localparam int C_AR = 0, C_DUR = 1, C_PRB = 4, C_LVL = 6, C_SWT = 7, C_RSP = 8;
    localparam logic [1:0] PM_ALWAYS = 2'h0, PM_POWER = 2'h1, PM_RUN = 2'h2;
    localparam logic [2:0] RSP_ALARM = 3'h6;
    localparam logic [1:0] SM_NONE = 2'h0, SM_FW = 2'h1, SM_FAST = 2'h2, SM_DC = 2'h3;
    typedef enum logic [1:0] {RS_IDLE, RS_WAIT, RS_TRY, RS_LOCK} dfrm_rs_e;
    typedef struct packed {
        logic ext_fault; logic override_on; logic reset_in; logic line_ok;
        logic phase_ok; logic overvolt; logic run_term; logic local_in;
        logic stop_fw; logic stop_fast; logic stop_dc; logic safe_off;
        logic contactor_fb; logic probe_hot; logic power_on; logic motor_on;
        logic ref_ok; logic test_done; logic test_ok;
    } dfrm_pin_s;
    typedef struct packed {
        logic net_run; logic key_run; logic key_reset; logic key_local;
        logic comm_loss; logic comm_rx;
    } dfrm_cmd_s;
    typedef struct packed {
        logic motor_run; logic contactor_close; logic fault_relay; logic trip;
        logic locked; logic local_mode; logic [1:0] stop_mode;
        logic [2:0] response; logic test_run;
    } dfrm_out_s;
endpackage

// ===== design/dfrm_top.sv
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module dfrm_top import dfrm_pkg::*; #(
    parameter int SEC_CYC = TICK_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire dfrm_pin_s   pins,
    input  wire dfrm_cmd_s   cmd,
    output dfrm_out_s        outs
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        dfrm_pin_s       s1;
        dfrm_pin_s       s2;
        logic            ovr_q;
        logic            rst_q;
        logic            run_q;
        logic [NF-1:0]   flt;
        logic [2:0]      last;
        logic [31:0]     div;
        logic            tick;
        logic [13:0]     wait_s;
        logic [13:0]     total_s;
        logic [13:0]     cont_s;
        logic [1:0]      tries;
        dfrm_rs_e        rs;
        logic [1:0]      stop;
        logic            armed;
        logic            lock;
        logic            pwr_test;
        logic            busy;
        logic [15:0]     ctrl;
        logic [13:0]     ctmo;
        logic [31:0]     rdata;
        logic            rdy;
        logic            err;
        dfrm_out_s       o;
    } dfrm_st_s;

    dfrm_st_s st;
    dfrm_st_s next_st;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [13:0] wait_for(input logic [1:0] n);
        unique case (n)
            2'h0:    wait_for = WAIT1_S;
            2'h1:    wait_for = WAIT2_S;
            2'h2:    wait_for = WAIT3_S;
            default: wait_for = WAIT4_S;
        endcase
    endfunction

    function automatic logic [13:0] dur_for(input logic [2:0] c);
        unique case (c)
            3'h0:    dur_for = DUR_5M;
            3'h1:    dur_for = DUR_10M;
            3'h2:    dur_for = DUR_30M;
            3'h3:    dur_for = DUR_1H;
            3'h4:    dur_for = DUR_2H;
            default: dur_for = DUR_3H;
        endcase
    endfunction

    logic            mon;
    logic            run_req;
    logic            clr_req;
    logic            unl;
    logic [NF-1:0]   src;
    logic [NF-1:0]   set;
    logic [NF-1:0]   clr;
    logic [1:0]      pmode;
    logic            wr;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_st = st;
        // two-stage pin synchroniser
        next_st.s1 = pins;
        next_st.s2 = st.s1;
        next_st.ovr_q = st.s2.override_on;
        next_st.rst_q = st.s2.reset_in;
        mon = st.s2.override_on;
        pmode = st.ctrl[C_PRB +: 2];
        unl = (st.ctrl[C_DUR +: 3] > 3'h5);
        wr = psel & penable & st.rdy & pwrite;

        // one second tick
        next_st.tick = 1'b0;
        if (st.div >= 32'(SEC_CYC - 1)) begin
            next_st.div = 32'h0000_0000;
            next_st.tick = 1'b1;
        end else begin
            next_st.div = st.div + 32'h0000_0001;
        end

        // forced local mode selects the command sources
        next_st.o.local_mode = st.s2.local_in | cmd.key_local;
        if (next_st.o.local_mode) begin
            run_req = st.s2.run_term | cmd.key_run;
        end else begin
            run_req = st.s2.run_term | cmd.key_run | cmd.net_run;
        end
        next_st.run_q = run_req;

        // stop arbitration, first active mode kept
        if (st.stop == SM_FW && !st.s2.stop_fw) next_st.stop = SM_NONE;
        if (st.stop == SM_FAST && !st.s2.stop_fast) next_st.stop = SM_NONE;
        if (st.stop == SM_DC && !st.s2.stop_dc) next_st.stop = SM_NONE;
        if (st.stop == SM_NONE) begin
            if (st.s2.stop_fw) next_st.stop = SM_FW;
            else if (st.s2.stop_fast) next_st.stop = SM_FAST;
            else if (st.s2.stop_dc) next_st.stop = SM_DC;
        end
        if (st.s2.safe_off) next_st.stop = SM_FW;

        // fault sources
        src = '0;
        src[F_EXT] = (st.s2.ext_fault == st.ctrl[C_LVL]);
        src[F_UNDERV] = !st.s2.line_ok;
        src[F_PHASE] = !st.s2.phase_ok;
        src[F_COMM] = cmd.comm_loss;
        src[F_OVV] = st.s2.overvolt;
        unique case (pmode)
            PM_POWER: src[F_PROBE] = st.s2.probe_hot & st.s2.power_on;
            PM_RUN:   src[F_PROBE] = st.s2.probe_hot & st.s2.motor_on;
            default:  src[F_PROBE] = st.s2.probe_hot;
        endcase
        if (st.o.contactor_close && !st.s2.contactor_fb) begin
            if (st.tick) next_st.cont_s = st.cont_s + 14'h0001;
        end else begin
            next_st.cont_s = 14'h0000;
        end
        src[F_CONT] = st.o.contactor_close && (st.cont_s >= st.ctmo);

        // switch test before each start; the power-on request sees the enable still clear
        if (st.ctrl[C_SWT] && !st.busy &&
            (st.pwr_test || (run_req && !st.run_q))) begin
            next_st.busy = 1'b1;
        end
        next_st.pwr_test = 1'b0;
        if (st.busy && st.s2.test_done) begin
            next_st.busy = 1'b0;
            src[F_SWT] = !st.s2.test_ok;
        end

        // latch, clear; a set wins over a clear
        set = mon ? src : '0;
        clr = '0;
        clr_req = (st.s2.reset_in & !st.rst_q) | cmd.key_reset |
                  (wr && paddr == OFF_ACT && pwdata[0]);
        if (clr_req && RESET_MASK[st.last]) begin
            clr[st.last] = 1'b1;
            next_st.armed = 1'b0;
            // next request goes to an older fault still latched
            for (int i = 0; i < NF; i++) begin
                if (st.flt[i] && RESET_MASK[i] && 3'(i) != st.last) next_st.last = 3'(i);
            end
        end
        if (st.s2.line_ok) clr[F_UNDERV] = 1'b1;
        if (st.s2.phase_ok) clr[F_PHASE] = 1'b1;
        if (cmd.comm_rx) clr[F_COMM] = 1'b1;
        if (st.s2.override_on != st.ovr_q) clr = '1;
        for (int i = 0; i < NF; i++) begin
            if (set[i] && !st.flt[i]) next_st.last = 3'(i);
        end

        // automatic restart sequencing
        if (!run_req) next_st.armed = 1'b1;
        if ((st.rs == RS_WAIT || st.rs == RS_TRY) && st.tick) begin
            next_st.wait_s = st.wait_s + 14'h0001;
            next_st.total_s = st.total_s + 14'h0001;
        end
        unique case (st.rs)
            RS_IDLE: begin
                if (|(st.flt & RESTART_MASK) &&
                    (st.ctrl[C_AR] || st.flt[F_UNDERV])) begin
                    next_st.rs = RS_WAIT;
                    next_st.wait_s = 14'h0000;
                    next_st.total_s = 14'h0000;
                    next_st.tries = 2'h0;
                end
            end
            RS_WAIT: begin
                if (!unl && st.total_s >= dur_for(st.ctrl[C_DUR +: 3])) begin
                    next_st.rs = RS_LOCK;
                end else if (st.wait_s >= wait_for(st.tries) &&
                             !(|(src & st.flt)) && st.s2.ref_ok &&
                             run_req && st.stop == SM_NONE &&
                             !st.s2.safe_off) begin
                    clr = clr | RESTART_MASK;
                    next_st.rs = RS_TRY;
                    next_st.armed = 1'b1;
                    if (st.tries != 2'h3) next_st.tries = st.tries + 2'h1;
                end
            end
            RS_TRY: begin
                if (!unl && st.total_s >= dur_for(st.ctrl[C_DUR +: 3])) begin
                    next_st.rs = RS_LOCK;
                end else if (|st.flt) begin
                    next_st.rs = RS_WAIT;
                    next_st.wait_s = 14'h0000;
                end else if (st.s2.motor_on) begin
                    next_st.rs = RS_IDLE;
                end
            end
            RS_LOCK: begin
                next_st.lock = 1'b1;
            end
        endcase
        next_st.flt = (st.flt & ~clr) | set;

        // outputs
        next_st.o.trip = mon & ((|st.flt) | st.lock);
        next_st.o.locked = st.lock;
        next_st.o.response = next_st.o.trip ? st.ctrl[C_RSP +: 3] : 3'h0;
        next_st.o.fault_relay = next_st.o.trip |
            (st.ctrl[C_AR] && (st.rs == RS_WAIT || st.rs == RS_TRY));
        next_st.o.stop_mode = st.stop;
        next_st.o.test_run = st.busy;
        next_st.o.motor_run = run_req && st.armed && !st.busy &&
            st.stop == SM_NONE && !st.s2.safe_off &&
            !(next_st.o.trip && st.ctrl[C_RSP +: 3] != RSP_ALARM);
        if (st.s2.safe_off) begin
            next_st.o.contactor_close = 1'b0;
        end else begin
            next_st.o.contactor_close = run_req |
                (st.o.contactor_close & st.s2.motor_on);
        end

        // apb slave, one wait-free access phase
        next_st.rdy = psel & !penable;
        next_st.err = 1'b0;
        next_st.rdata = 32'h0000_0000;
        if (psel && !penable) begin
            unique case (paddr)
                OFF_CTRL: next_st.rdata = {16'h0000, st.ctrl};
                OFF_CTMO: next_st.rdata = {18'h00000, st.ctmo};
                OFF_STAT: next_st.rdata = {16'h0000, st.busy, st.lock,
                                           st.stop, st.tries, st.rs, st.flt};
                OFF_ACT:  next_st.rdata = 32'h0000_0000;
                default:  next_st.err = 1'b1;
            endcase
        end else if (psel) begin
            next_st.err = st.err;
        end
        if (wr && paddr == OFF_CTRL) next_st.ctrl = pwdata[15:0];
        if (wr && paddr == OFF_CTMO) next_st.ctmo = pwdata[13:0];
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.s1.override_on <= 1'b1;
            st.s2.override_on <= 1'b1;
            st.ovr_q <= 1'b1;
            st.s1.line_ok <= 1'b1;
            st.s2.line_ok <= 1'b1;
            st.s1.phase_ok <= 1'b1;
            st.s2.phase_ok <= 1'b1;
            st.s1.ext_fault <= 1'b1;                      // inactive for reset level
            st.s2.ext_fault <= 1'b1;
            st.rs <= RS_IDLE;
            st.pwr_test <= 1'b1;
            st.ctrl <= CTRL_RST;
            st.ctmo <= CTMO_RST;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.rdata;
    assign pready = st.rdy;
    assign pslverr = st.err;
    assign outs = st.o;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence early_wait;
        st.rs == RS_WAIT && st.tries == 2'h0 && st.wait_s < WAIT1_S;
    endsequence
    sequence try_taken;
        ##1 st.rs == RS_TRY;
    endsequence

    first_wait_a: assert property (early_wait |-> not try_taken)
        else $error("restart tried before the first wait");
    lock_sticky_a: assert property (st.lock |=> st.lock && st.rs == RS_LOCK)
        else $error("lock released without power cycle");
    inhibit_a: assert property (!st.s2.override_on |=> !outs.trip)
        else $error("fault shown while monitoring is off");
    safe_off_a: assert property (st.s2.safe_off |=> !outs.motor_run ##1 !outs.motor_run)
        else $error("motor runs under safe power removal");
    stop_keep_a: assert property (st.stop == SM_FW && st.s2.stop_fw && !st.s2.safe_off
        |=> st.stop == SM_FW)
        else $error("first stop mode displaced");
    line_clr_a: assert property (st.s2.line_ok [*2] |-> !st.flt[F_UNDERV])
        else $error("undervoltage not cleared on line return");
    comm_clr_a: assert property (cmd.comm_rx && !cmd.comm_loss
        |=> !st.flt[F_COMM])
        else $error("network fault kept after new command");
    relay_a: assert property (st.ctrl[C_AR] && st.rs == RS_WAIT
        |=> outs.fault_relay)
        else $error("fault relay dropped during restart");
    ext_set_a: assert property (st.s2.override_on && st.ovr_q &&
        st.s2.ext_fault == st.ctrl[C_LVL] |=> (st.flt[F_EXT] and
        (st.s2.override_on |=> outs.trip)))
        else $error("external fault not latched");
    contactor_a: assert property ($rose(st.run_q) && !st.s2.safe_off
        |-> ##[0:1] outs.contactor_close)
        else $error("contactor not closed on run");
endmodule // dfrm_top

// ===== tb/dfrm_far_model.sv
`timescale 1ns/1ns
// ****************************************
// inputs, keypad and network seen by the unit
// ****************************************
module dfrm_far_model import dfrm_pkg::*; (
    input  wire dfrm_out_s outs,
    output dfrm_pin_s      pins,
    output dfrm_cmd_s      cmd
);
    dfrm_pin_s pv;    // levels set by the bench
    dfrm_cmd_s cv;    // keypad and network commands
    logic      fb_en; // contactor feedback wired up

    // idle: line healthy, monitoring on, ext input idle high
    initial begin
        pv = '0;
        pv.override_on = 1'b1;
        pv.line_ok = 1'b1;
        pv.phase_ok = 1'b1;
        pv.ext_fault = 1'b1;
        pv.ref_ok = 1'b1;
        cv = '0;
        fb_en = 1'b1;
    end

    // contactor, motor and switch test follow the unit's outputs
    always_comb begin
        pins = pv;
        pins.contactor_fb = fb_en & outs.contactor_close;
        pins.motor_on = outs.motor_run;
        pins.test_done = outs.test_run;
        pins.test_ok = 1'b1;
    end

    assign cmd = cv;
endmodule // dfrm_far_model

// ===== tb/drive_fault_restart_manager_tb.sv
`timescale 1ns/1ns
module drive_fault_restart_manager_tb import dfrm_pkg::*;;
    // ****************************************
    // bench, queue and bus tasks
    // ****************************************
    localparam int SEC = 20; // cycles per tick in sim
    localparam logic [31:0] LV = 32'h00000040; // ext input active high
    typedef struct packed {
        logic c; logic er; logic [31:0] e; logic [31:0] m;
    } dfrm_note_s;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, last_rd, rnd;
    logic [11:0] ov;
    dfrm_pin_s   pins;
    dfrm_cmd_s   cmd;
    dfrm_out_s   outs;
    dfrm_note_s  nq[$];
    dfrm_note_s  nt;
    int          n_errors, n_compared, cyc;
    logic [1:0]  pm[4] = '{2'h0, 2'h1, 2'h1, 2'h2};
    logic        pw[4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    logic        pe[4] = '{1'b1, 1'b0, 1'b1, 1'b0};

    assign ov = outs;
    dfrm_top #(.SEC_CYC(SEC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
        .cmd(cmd), .outs(outs));
    dfrm_far_model far (.outs(outs), .pins(pins), .cmd(cmd));

    initial pclk = 1'b0;
    always #25 pclk = ~pclk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // one transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input logic c);
        nq.push_back('{c, a > 8'h0C, e, m});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic poll(input logic [31:0] m, v, input int lim);
        for (int i = 0; i < lim; i++) begin
            rd(OFF_STAT, v, m, 1'b0);
            if ((last_rd & m) === v) break;
        end
        rd(OFF_STAT, v, m, 1'b1);
    endtask
    task automatic wait_o(input logic [11:0] m, v, input int lim);
        for (int i = 0; i < lim && (ov & m) !== v; i++) @(posedge pclk);
        check({20'h0, ov & m}, {20'h0, v});
    endtask
    task automatic do_reset;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check({20'h0, ov}, 32'h0);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask
    // each change of the override input wipes the latched faults
    task automatic clear_all;
        far.pv.override_on <= 1'b0;
        repeat (8) @(posedge pclk);
        far.pv.override_on <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask
    task automatic set_stop(input int k, input logic v);
        case (k)
            1: far.pv.stop_fw <= v;
            2: far.pv.stop_fast <= v;
            default: far.pv.stop_dc <= v;
        endcase
    endtask

    // read results taken off the queue as they appear
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            nt = nq.pop_front();
            last_rd = prdata;
            if (nt.c) begin
                check(prdata & nt.m, nt.e);
                check({31'h0, pslverr}, {31'h0, nt.er});
            end
        end
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc > 30000) begin
            n_errors++;
            $display("MISMATCH t=%0t timeout", $time);
            end_sim;
        end
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        {n_errors, n_compared, cyc} = '0;
        rnd = $urandom(85);
        do_reset;
        rd(OFF_CTRL, 32'h0, 32'hFFFF, 1'b1);
        rd(OFF_CTMO, 32'h5, 32'h3FFF, 1'b1);
        rd(8'h10, 32'h0, 32'hFFFFFFFF, 1'b1);
        rnd = $urandom() & 32'h3FFF;
        apb(1'b1, OFF_CTMO, rnd);
        rd(OFF_CTMO, rnd, 32'h3FFF, 1'b1);
        apb(1'b1, OFF_CTMO, 32'h2);
        $display("test done: registers");
        for (int l = 0; l < 2; l++) begin
            apb(1'b1, OFF_CTRL, l << C_LVL);
            far.pv.ext_fault <= 1'(l);
            poll(32'h1, 32'h1, 20);
            far.pv.ext_fault <= 1'(~l);
            clear_all;
            poll(32'hFF, 32'h0, 20);
        end
        far.pv.override_on <= 1'b0;
        far.pv.ext_fault <= 1'b1;
        far.pv.probe_hot <= 1'b1;
        repeat (10) @(posedge pclk);
        rd(OFF_STAT, 32'h0, 32'h3, 1'b1);
        far.pv.override_on <= 1'b1;
        poll(32'h3, 32'h3, 20);
        far.pv.ext_fault <= 1'b0;
        far.pv.probe_hot <= 1'b0;
        repeat (10) @(posedge pclk);
        apb(1'b1, OFF_ACT, 32'h1);
        poll(32'h3, 32'h1, 10);
        apb(1'b1, OFF_ACT, 32'h1);
        poll(32'h3, 32'h0, 10);
        $display("test done: fault latch and reset");
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFF_CTRL, LV | 32'(pm[i]) << C_PRB);
            far.pv.power_on <= pw[i];
            far.pv.probe_hot <= 1'b1;
            repeat (10) @(posedge pclk);
            rd(OFF_STAT, 32'(pe[i]) << 1, 32'h2, 1'b1);
            far.pv.probe_hot <= 1'b0;
            far.pv.power_on <= 1'b0;
            clear_all;
        end
        for (int r = 0; r < 7; r++) begin
            apb(1'b1, OFF_CTRL, LV | 32'(r) << C_RSP);
            far.pv.probe_hot <= 1'b1;
            wait_o(12'h10E, 12'h100 | 12'(r) << 1, 20);
            far.pv.probe_hot <= 1'b0;
            clear_all;
        end
        far.pv.line_ok <= 1'b0;
        poll(32'h304, 32'h104, 20);
        far.pv.line_ok <= 1'b1;
        poll(32'h4, 32'h0, 20);
        far.pv.phase_ok <= 1'b0;
        poll(32'h8, 32'h8, 20);
        far.pv.phase_ok <= 1'b1;
        poll(32'h8, 32'h0, 20);
        far.cv.comm_loss <= 1'b1;
        poll(32'h10, 32'h10, 10);
        far.cv.comm_loss <= 1'b0;
        repeat (10) @(posedge pclk);
        rd(OFF_STAT, 32'h10, 32'h10, 1'b1);
        far.cv.comm_rx <= 1'b1;
        @(posedge pclk);
        far.cv.comm_rx <= 1'b0;
        poll(32'h10, 32'h0, 10);
        clear_all;
        $display("test done: automatic clears");
        apb(1'b1, OFF_CTRL, LV | 32'h80);
        far.pv.run_term <= 1'b1;
        wait_o(12'h001, 12'h001, 20);
        wait_o(12'h400, 12'h400, 40);
        wait_o(12'h800, 12'h800, 40);
        for (int i = 0; i < 3; i++) begin
            set_stop(i + 1, 1'b1);
            repeat (6) @(posedge pclk);
            set_stop((i + 1) % 3 + 1, 1'b1);
            wait_o(12'h830, 12'(i + 1) << 4, 20);
            set_stop(i + 1, 1'b0);
            set_stop((i + 1) % 3 + 1, 1'b0);
            wait_o(12'h030, 12'h000, 20);
        end
        wait_o(12'h800, 12'h800, 40);
        far.pv.safe_off <= 1'b1;
        wait_o(12'h800, 12'h000, 20);
        far.pv.safe_off <= 1'b0;
        wait_o(12'h800, 12'h800, 40);
        apb(1'b1, OFF_ACT, 32'h1);
        repeat (6) @(posedge pclk);
        wait_o(12'h800, 12'h000, 1);
        far.pv.run_term <= 1'b0;
        wait_o(12'h400, 12'h000, 20);
        far.fb_en <= 1'b0;
        far.pv.run_term <= 1'b1;
        poll(32'h40, 32'h40, 60);
        far.pv.run_term <= 1'b0;
        far.fb_en <= 1'b1;
        clear_all;
        far.pv.local_in <= 1'b1;
        far.cv.net_run <= 1'b1;
        wait_o(12'h040, 12'h040, 20);
        repeat (20) @(posedge pclk);
        wait_o(12'h800, 12'h000, 1);
        far.pv.local_in <= 1'b0;
        wait_o(12'h840, 12'h800, 40);
        far.cv.net_run <= 1'b0;
        far.cv.key_local <= 1'b1;
        wait_o(12'h040, 12'h040, 20);
        far.cv.key_local <= 1'b0;
        $display("test done: run, stops, local");
        apb(1'b1, OFF_CTRL, LV | 32'h1);
        far.pv.run_term <= 1'b1;
        wait_o(12'h800, 12'h800, 40);
        far.pv.ext_fault <= 1'b1;
        poll(32'h301, 32'h101, 20);
        wait_o(12'h200, 12'h200, 20);
        repeat (3 * SEC) @(posedge pclk);
        rd(OFF_STAT, 32'h1, 32'h1, 1'b1);
        far.pv.ext_fault <= 1'b0;
        poll(32'h301, 32'h0, 120);
        wait_o(12'h800, 12'h800, 40);
        far.pv.ext_fault <= 1'b1;
        repeat (200 * SEC) @(posedge pclk);
        rd(OFF_STAT, 32'h0, 32'h4000, 1'b1);
        poll(32'h4300, 32'h4300, 1500);
        wait_o(12'h080, 12'h080, 4);
        far.pv.ext_fault <= 1'b0;
        apb(1'b1, OFF_ACT, 32'h1);
        repeat (80 * SEC) @(posedge pclk);
        rd(OFF_STAT, 32'h4000, 32'h4000, 1'b1);
        do_reset;
        rd(OFF_STAT, 32'h0, 32'h4000, 1'b1);
        $display("test done: restart and lock");
        end_sim;
    end
endmodule // drive_fault_restart_manager_tb
